// ---- dcp_pkg.sv ----
// Shared constants, field layouts and carrier types of the dual channel pulse unit
package dcp_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHANNELS = 2;
  localparam int unsigned COUNTER_W = 8;
  localparam int unsigned PRESCALE_W = 2;
  localparam int unsigned SELECT_W = 2;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CONTROL_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CONTROL_THREE = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_ZERO = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_ONE = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_COUNTER = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE_ZERO = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE_ONE = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h7;

  // Field positions of modulator_control_one
  localparam int unsigned RUN_BIT = 7;
  localparam int unsigned CLEAR_BIT = 6;
  localparam int unsigned OE_LSB = 0;

  // Field positions of modulator_control_three
  localparam int unsigned SELECT_LSB = 0;
  localparam int unsigned PRESCALE_LSB = 4;

  // Field positions of the status register
  localparam int unsigned STATUS_LEVEL_LSB = 0;
  localparam int unsigned STATUS_RUN_BIT = 4;
  localparam int unsigned STATUS_OPTION_BIT = 5;

  // Reset values
  localparam logic [DATA_W-1:0] COMPARE_RESET = 8'h00;
  localparam logic [COUNTER_W-1:0] COUNTER_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  typedef enum logic [SELECT_W-1:0] {
    DCP_SRC_CPU = 2'h0,
    DCP_SRC_TIMER0 = 2'h1,
    DCP_SRC_TIMER1 = 2'h2,
    DCP_SRC_NONE = 2'h3
  } dcp_clk_src_e;

  typedef struct packed {
    logic run;
    logic [CHANNELS-1:0] oe;
    dcp_clk_src_e src;
    logic [PRESCALE_W-1:0] prescale;
  } dcp_ctrl_s;

  localparam dcp_ctrl_s CTRL_RESET = '{run: 1'b0, oe: 2'h0, src: DCP_SRC_CPU, prescale: 2'h0};

endpackage

// ---- dcp_tick_gen.sv ----
// Counter clock source select and prescale divider of the pulse unit
`timescale 1ns/1ps
`default_nettype none

module dcp_tick_gen #(
  parameter int unsigned PRESCALE_W = dcp_pkg::PRESCALE_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire dcp_pkg::dcp_clk_src_e src,
  input wire logic [PRESCALE_W-1:0] prescale,
  input wire logic run,
  input wire logic clear,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  output logic tick
);

  localparam int unsigned DIV_W = (1 << PRESCALE_W) - 1;

  generate
    if (PRESCALE_W < 1 || PRESCALE_W > 4) begin : g_bad_width
      $error("dcp_tick_gen: PRESCALE_W must be 1 to 4");
    end
  endgenerate

  logic src_pulse;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] div_mask;

  // Pick the raw counter clock event
  always_comb begin
    case (src)
      dcp_pkg::DCP_SRC_CPU: src_pulse = 1'b1;
      dcp_pkg::DCP_SRC_TIMER0: src_pulse = timer0_overflow;
      dcp_pkg::DCP_SRC_TIMER1: src_pulse = timer1_overflow;
      default: src_pulse = 1'b0;
    endcase
  end

  // Divide by two to the power of the prescale code
  assign div_mask = DIV_W'((1 << prescale) - 1);

  always_ff @(posedge clk) begin
    if (reset || clear || !run) begin
      div <= '0;
    end else if (src_pulse) begin
      div <= DIV_W'(div + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || clear || !run) begin
      tick <= 1'b0;
    end else begin
      tick <= src_pulse && ((div & div_mask) == div_mask);
    end
  end

endmodule

`default_nettype wire

// ---- dcp_pulse_unit.sv ----
// Two channel pulse width modulator with shared 8-bit counter and register port
`timescale 1ns/1ps
`default_nettype none

module dcp_pulse_unit #(
  parameter int unsigned COUNTER_W = dcp_pkg::COUNTER_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_level_high_option,
  input wire logic [dcp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dcp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [dcp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic port_latch_zero,
  input wire logic port_latch_one,
  output logic pulse_out_zero,
  output logic pulse_out_one
);

  localparam int unsigned CH = dcp_pkg::CHANNELS;
  localparam int unsigned DW = dcp_pkg::DATA_W;
  localparam logic [COUNTER_W-1:0] COUNT_MAX = {COUNTER_W{1'b1}};
  localparam logic [COUNTER_W-1:0] COUNT_ZERO = '0;

  generate
    if (COUNTER_W < 2 || COUNTER_W > dcp_pkg::DATA_W) begin : g_bad_counter
      $error("dcp_pulse_unit: COUNTER_W must be 2 to DATA_W");
    end
  endgenerate

  dcp_pkg::dcp_ctrl_s ctrl;
  logic reset_level;
  logic clear_pulse;
  logic tick;
  logic advance;
  logic overflow;
  logic [COUNTER_W-1:0] counter;
  logic [COUNTER_W-1:0] next_counter;
  logic [COUNTER_W-1:0] shadow [CH];
  logic [COUNTER_W-1:0] active [CH];
  logic [CH-1:0] level;
  logic [CH-1:0] next_level;
  logic [CH-1:0] port_latch;
  logic [CH-1:0] pin;
  logic [DW-1:0] next_rdata;

  assign port_latch = {port_latch_one, port_latch_zero};

  // Register writes: control fields
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= dcp_pkg::CTRL_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        dcp_pkg::OFF_CONTROL_ONE: begin
          ctrl.run <= reg_wdata[dcp_pkg::RUN_BIT];
          ctrl.oe <= reg_wdata[dcp_pkg::OE_LSB +: CH];
        end
        dcp_pkg::OFF_CONTROL_THREE: begin
          ctrl.src <= dcp_pkg::dcp_clk_src_e'(reg_wdata[dcp_pkg::SELECT_LSB +: dcp_pkg::SELECT_W]);
          ctrl.prescale <= reg_wdata[dcp_pkg::PRESCALE_LSB +: dcp_pkg::PRESCALE_W];
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // Counter clear is a self-clearing command bit
  always_ff @(posedge clk) begin
    if (reset) begin
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= reg_write && (reg_addr == dcp_pkg::OFF_CONTROL_ONE)
        && reg_wdata[dcp_pkg::CLEAR_BIT];
    end
  end

  // Reset level strap is caught while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      reset_level <= reset_level_high_option;
    end
  end

  dcp_tick_gen #(
    .PRESCALE_W(dcp_pkg::PRESCALE_W)
  ) u_tick_gen (
    .clk(clk),
    .reset(reset),
    .src(ctrl.src),
    .prescale(ctrl.prescale),
    .run(ctrl.run),
    .clear(clear_pulse),
    .timer0_overflow(timer0_overflow),
    .timer1_overflow(timer1_overflow),
    .tick(tick)
  );

  // Counter steps only when running and the divided clock ticks
  assign advance = tick && ctrl.run && !clear_pulse;
  assign overflow = advance && (counter == COUNT_MAX);
  assign next_counter = COUNTER_W'(counter + 1'b1);

  // Shared up-counter, wraps to zero
  always_ff @(posedge clk) begin
    if (reset) begin
      counter <= dcp_pkg::COUNTER_RESET[COUNTER_W-1:0];
    end else if (clear_pulse) begin
      counter <= COUNT_ZERO;
    end else if (advance) begin
      counter <= next_counter;
    end
  end

  localparam int unsigned ADDR_W_LOC = dcp_pkg::ADDR_W;

  // Per-channel compare buffers, output level and pin
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_chan
      logic [COUNTER_W-1:0] cmp_now;
      logic [ADDR_W_LOC-1:0] cmp_off;

      assign cmp_off = (g == 0) ? dcp_pkg::OFF_COMPARE_ZERO : dcp_pkg::OFF_COMPARE_ONE;

      // Software side compare value
      always_ff @(posedge clk) begin
        if (reset) begin
          shadow[g] <= dcp_pkg::COMPARE_RESET[COUNTER_W-1:0];
        end else if (reg_write && (reg_addr == cmp_off)) begin
          shadow[g] <= reg_wdata[COUNTER_W-1:0];
        end
      end

      // Working buffer takes the new value only at overflow
      always_ff @(posedge clk) begin
        if (reset) begin
          active[g] <= dcp_pkg::COMPARE_RESET[COUNTER_W-1:0];
        end else if (overflow) begin
          active[g] <= shadow[g];
        end
      end

      // Compare value in force for the count being entered
      assign cmp_now = overflow ? shadow[g] : active[g];

      always_comb begin
        next_level[g] = level[g];
        if (advance) begin
          if (cmp_now == COUNT_ZERO) begin
            next_level[g] = 1'b1;
          end else if (cmp_now == COUNT_MAX) begin
            next_level[g] = 1'b0;
          end else if (next_counter == cmp_now) begin
            next_level[g] = 1'b0;
          end else if (next_counter == COUNT_ZERO) begin
            next_level[g] = 1'b1;
          end
        end
      end

      // Level only moves on counter steps, so stopping freezes it
      always_ff @(posedge clk) begin
        if (reset) begin
          level[g] <= reset_level_high_option;
        end else begin
          level[g] <= next_level[g];
        end
      end

      // Pin mux between modulator and ordinary port latch
      always_ff @(posedge clk) begin
        if (reset) begin
          pin[g] <= reset_level_high_option;
        end else if (ctrl.oe[g]) begin
          pin[g] <= level[g];
        end else begin
          pin[g] <= port_latch[g];
        end
      end
    end
  endgenerate

  // Each channel drives its own dedicated pin
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_out_zero <= reset_level_high_option;
      pulse_out_one <= reset_level_high_option;
    end else begin
      pulse_out_zero <= pin[0];
      pulse_out_one <= pin[1];
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    next_rdata = dcp_pkg::READ_IDLE;
    case (reg_addr)
      dcp_pkg::OFF_CONTROL_ONE: begin
        next_rdata[dcp_pkg::RUN_BIT] = ctrl.run;
        next_rdata[dcp_pkg::OE_LSB +: CH] = ctrl.oe;
      end
      dcp_pkg::OFF_CONTROL_THREE: begin
        next_rdata[dcp_pkg::SELECT_LSB +: dcp_pkg::SELECT_W] = ctrl.src;
        next_rdata[dcp_pkg::PRESCALE_LSB +: dcp_pkg::PRESCALE_W] = ctrl.prescale;
      end
      dcp_pkg::OFF_COMPARE_ZERO: begin
        next_rdata[COUNTER_W-1:0] = shadow[0];
      end
      dcp_pkg::OFF_COMPARE_ONE: begin
        next_rdata[COUNTER_W-1:0] = shadow[1];
      end
      dcp_pkg::OFF_COUNTER: begin
        next_rdata[COUNTER_W-1:0] = counter;
      end
      dcp_pkg::OFF_ACTIVE_ZERO: begin
        next_rdata[COUNTER_W-1:0] = active[0];
      end
      dcp_pkg::OFF_ACTIVE_ONE: begin
        next_rdata[COUNTER_W-1:0] = active[1];
      end
      dcp_pkg::OFF_STATUS: begin
        next_rdata[dcp_pkg::STATUS_LEVEL_LSB +: CH] = level;
        next_rdata[dcp_pkg::STATUS_RUN_BIT] = ctrl.run;
        next_rdata[dcp_pkg::STATUS_OPTION_BIT] = reset_level;
      end
      default: begin
        next_rdata = dcp_pkg::READ_IDLE;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= dcp_pkg::READ_IDLE;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= dcp_pkg::READ_IDLE;
    end
  end

endmodule

`default_nettype wire

// ---- dcp_load.sv ----
// Load on one pulse pin: measures the last low time and period
`timescale 1ns/1ps
`default_nettype none
module dcp_load (
  input wire logic clk,
  input wire logic pin,
  output logic [15:0] low_len,
  output logic [15:0] period
);
  logic [15:0] lo = 16'h0000;
  logic [15:0] per = 16'h0000;
  logic last = 1'b0;
  always_ff @(posedge clk) begin
    last <= pin;
    lo <= pin ? 16'h0000 : lo + 16'h0001;
    per <= (pin && !last) ? 16'h0001 : per + 16'h0001;
    if (pin && !last) begin
      low_len <= lo;
      period <= per;
    end
  end
endmodule
`default_nettype wire

// ---- dcp_pulse_unit_checker.sv ----
// Port assertions of the pulse unit
`timescale 1ns/1ps
`default_nettype none
module dcp_pulse_unit_checker #(
  parameter int unsigned COUNTER_W = dcp_pkg::COUNTER_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_level_high_option,
  input wire logic [dcp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dcp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [dcp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic port_latch_zero,
  input wire logic port_latch_one,
  input wire logic pulse_out_zero,
  input wire logic pulse_out_one
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic run_q;
  logic oe_q;
  logic [2:0] idle;
  logic [1:0] clr;
  logic [7:0] cfg;
  logic [7:0] cmp;
  logic [9:0] age;
  logic [8:0] lo;
  wire wr1 = reg_write && reg_addr == 4'h0;
  // Steady fast run: no write for 600 cycles, CPU clock undivided
  wire fast = run_q && oe_q && cfg == 8'h00 && age == 10'h258;
  always_ff @(posedge clk) begin
    if (reset || wr1) begin
      run_q <= !reset && reg_wdata[7];
      oe_q <= !reset && reg_wdata[0];
      idle <= 3'h0;
      clr <= {1'b0, !reset && reg_wdata[6] && !reg_wdata[7]};
    end else begin
      idle <= (idle == 3'h7) ? idle : idle + 3'h1;
      clr <= (clr == 2'h0 || clr == 2'h3) ? clr : clr + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    age <= (reset || reg_write) ? 10'h000 : (age == 10'h258) ? age : age + 10'h001;
    lo <= (reset || pulse_out_zero) ? 9'h000 : lo + 9'h001;
    if (reset) begin
      cfg <= 8'h00;
      cmp <= 8'h00;
    end else if (reg_write && reg_addr == 4'h1) begin
      cfg <= reg_wdata;
    end else if (reg_write && reg_addr == 4'h2) begin
      cmp <= reg_wdata;
    end
  end
  a_reset_level: assert property ($past(reset) |->
    {pulse_out_one, pulse_out_zero} == {2{$past(reset_level_high_option)}}) else $error("reset level");
  a_pin_port: assert property (idle == 3'h7 && !oe_q |->
    pulse_out_zero == $past(port_latch_zero, 2)) else $error("port level");
  a_counter_clear: assert property (reg_read && reg_addr == 4'h4 && clr == 2'h3
    |=> reg_rdata == 8'h00) else $error("counter not cleared");
  a_stop_hold: assert property (idle == 3'h7 && !run_q && oe_q |-> $stable(pulse_out_zero))
    else $error("pin moved while stopped");
  a_low_width: assert property ($rose(pulse_out_zero) && fast |->
    lo == 9'h100 - {1'b0, cmp}) else $error("low time");
  a_zero_high: assert property (fast && cmp == 8'h00 |-> pulse_out_zero)
    else $error("compare zero not high");
  a_full_low: assert property (fast && cmp == 8'hFF |-> !pulse_out_zero)
    else $error("compare full not low");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  c_width: cover property ($rose(pulse_out_zero) && fast);
  c_clear: cover property (reg_read && clr == 2'h3);
  c_hold: cover property (idle == 3'h7 && !run_q && oe_q);
endmodule
bind dcp_pulse_unit dcp_pulse_unit_checker #(.COUNTER_W(COUNTER_W)) u_checker (
  .clk(clk), .reset(reset), .reset_level_high_option(reset_level_high_option),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
  .port_latch_zero(port_latch_zero), .port_latch_one(port_latch_one),
  .pulse_out_zero(pulse_out_zero), .pulse_out_one(pulse_out_one));
`default_nettype wire

// ---- dcp_pulse_unit_tb.sv ----
// Self-checking bench of the pulse unit
`timescale 1ns/1ps
`default_nettype none
module dcp_pulse_unit_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic opt = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wen = 1'b0;
  logic ren = 1'b0;
  logic [7:0] rdata;
  logic t0 = 1'b0;
  logic t1 = 1'b0;
  logic pl0 = 1'b0;
  logic pl1 = 1'b0;
  logic p0;
  logic p1;
  logic [15:0] low0, low1, per0;
  int t0c = 0;
  int t1c = 0;
  int num_errors = 0;
  int comparisons = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Timer overflows every 3 and every 5 cycles
  always @(posedge clk) begin
    t0c <= (t0c == 2) ? 0 : t0c + 1;
    t1c <= (t1c == 4) ? 0 : t1c + 1;
    t0 <= (t0c == 0);
    t1 <= (t1c == 0);
  end
  dcp_pulse_unit dut (.clk(clk), .reset(reset), .reset_level_high_option(opt), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wen), .reg_read(ren), .reg_rdata(rdata), .timer0_overflow(t0),
    .timer1_overflow(t1), .port_latch_zero(pl0), .port_latch_one(pl1), .pulse_out_zero(p0),
    .pulse_out_one(p1));
  dcp_load u_load0 (.clk(clk), .pin(p0), .low_len(low0), .period(per0));
  dcp_load u_load1 (.clk(clk), .pin(p1), .low_len(low1), .period());
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wen <= 1'b1;
    @(posedge clk);
    wen <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    ren <= 1'b1;
    @(posedge clk);
    ren <= 1'b0;
    #1 chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic wait_rise(input int n);
    int k;
    int got;
    logic prev;
    got = 0;
    prev = p0;
    for (k = 0; k < 60000 && got < n; k++) begin
      @(posedge clk);
      #1 got += (p0 === 1'b1 && prev === 1'b0);
      prev = p0;
    end
    if (got < n) begin
      num_errors++;
      $display("CHECK FAILED rises expected %0d seen %0d", n, got);
      finish_test();
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    chk("pins", 16'h3, {p1, p0});
    rd(4'h7, 8'h23, "status");
    wr(4'h9, 8'hA5);
    rd(4'h9, 8'h00, "unmapped");
    rd(4'h0, 8'h00, "control one");
    @(posedge clk);
    reset <= 1'b1;
    opt <= 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk("pins", 16'h0, {p1, p0});
    rd(4'h7, 8'h00, "status");
    $display("test reset done");
  endtask
  task automatic t_port();
    int i;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      {pl1, pl0} <= i[1:0];
      repeat (3) @(posedge clk);
      #1 chk("port pins", 16'(i), {p1, p0});
    end
    $display("test port done");
  endtask
  task automatic t_pwm();
    int i;
    int div;
    wr(4'h2, 8'h40);
    wr(4'h3, 8'hC0);
    wr(4'h0, 8'hC0);
    for (i = 0; i < 6; i++) begin
      div = (i < 4) ? (1 << i) : (i == 4) ? 3 : 10;
      wr(4'h1, (i < 4) ? 8'(i << 4) : (i == 4) ? 8'h01 : 8'h12);
      wr(4'h0, 8'hC3);
      wait_rise(4);
      chk("period", 16'(256 * div), per0);
      chk("low0", 16'(192 * div), low0);
      chk("low1", 16'(64 * div), low1);
    end
    $display("test pwm done");
  endtask
  task automatic t_buffer();
    wr(4'h1, 8'h00);
    wait_rise(2);
    wr(4'h2, 8'h80);
    rd(4'h5, 8'h40, "active early");
    rd(4'h2, 8'h80, "compare");
    wait_rise(1);
    rd(4'h5, 8'h80, "active late");
    wait_rise(1);
    chk("low0", 16'h0080, low0);
    $display("test buffer done");
  endtask
  task automatic t_clear();
    wr(4'h0, 8'h03);
    wr(4'h0, 8'h43);
    repeat (2) @(posedge clk);
    rd(4'h4, 8'h00, "cleared");
    wr(4'h0, 8'h83);
    repeat (2) @(posedge clk);
    rd(4'h4, 8'h02, "counting");
    repeat (254) @(posedge clk);
    rd(4'h4, 8'h02, "wrapped");
    wr(4'h1, 8'h03);
    repeat (4) @(posedge clk);
    rd(4'h4, 8'h06, "no clock");
    wr(4'h1, 8'h00);
    $display("test clear done");
  endtask
  task automatic t_extremes();
    int i;
    int k;
    for (i = 0; i < 2; i++) begin
      wr(4'h2, i ? 8'hFF : 8'h00);
      wr(4'h3, i ? 8'h00 : 8'hFF);
      repeat (700) @(posedge clk);
      for (k = 0; k < 300; k++) begin
        @(posedge clk);
        #1 chk("fixed pins", i ? 16'h2 : 16'h1, {p1, p0});
      end
    end
    wr(4'h0, 8'h03);
    repeat (50) @(posedge clk);
    #1 chk("stopped pins", 16'h2, {p1, p0});
    $display("test extremes done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_port();
    t_pwm();
    t_buffer();
    t_clear();
    t_extremes();
    finish_test();
  end
endmodule
`default_nettype wire
